// ### nrw_write_host.sv
// Host controller running write cycles into a battery-backed timekeeping memory.
// Assumes the device pins are wired straight out; power status arrives synchronous.
//
// What this block does
// - The host holds the address steady through the whole write.
// - The host keeps strobe or select high for the recovery time before the next cycle.
// - The host gives data its setup time before and hold time after the write end.
// - The host keeps output drive high during writes.
// - The host treats a zero battery flag as lost time and memory contents.
// - The host writes zero to unused bits of the day register.
`timescale 1ns/100ps
module nrw_write_host (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reqValid,
  input nrw_pkg::nrw_req_type reqData,
  output logic reqReady,
  output logic writeDone,
  output logic writeRefused,
  input wire logic devReset_b,
  input wire logic dayRead,
  input wire logic [nrw_pkg::DATA_W-1:0] dayValue,
  output logic contentsLost,
  output nrw_pkg::nrw_pins_type pins
);
  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  nrw_pkg::nrw_state_type state_reg;
  nrw_pkg::nrw_state_type state_next;
  nrw_pkg::nrw_req_type hold_reg;
  logic chipSel_reg;
  logic writeStrobe_reg;
  logic dqOe_reg;
  logic done_reg;
  logic refused_reg;
  logic lost_reg;
  logic timerLoad;
  logic timerDone;
  logic [nrw_pkg::CNT_W-1:0] timerValue;
  logic take;
  logic powerGood;
  logic [nrw_pkg::DATA_W-1:0] cleanData;
  logic isDay;
  logic [nrw_pkg::DATA_W-1:0] keepBit;
  logic strobeNext;
  logic driveNext;
  logic isIdle;
  logic doneNext;
  logic refuseIdle;
  logic refuseLate;
  logic dayFlag;
  logic inFlight;
  logic lostWrite_reg;
  logic lostWrite_next;

  assign powerGood = devReset_b;
  assign reqReady = (state_reg == nrw_pkg::ST_IDLE) && powerGood;
  assign take = reqValid && reqReady;
  assign isDay = (reqData.addr == nrw_pkg::DAY_ADDR);

  // ----------------------------------------
  // Day register clean-up
  // ----------------------------------------
  // Reserved day bits go out low; the flag bit is read-only anyway
  for (genvar bitIdx = 0; bitIdx < nrw_pkg::DATA_W; bitIdx++) begin : g_dayBit
    assign keepBit[bitIdx] = !isDay || nrw_pkg::DAY_USED_MASK[bitIdx];
    assign cleanData[bitIdx] = reqData.data[bitIdx] && keepBit[bitIdx];
  end

  nrw_cycle_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    timerLoad = 1'b0;
    timerValue = 4'h0;
    case (state_reg)
      nrw_pkg::ST_IDLE: begin
        if (take) begin
          state_next = nrw_pkg::ST_SETUP;
          timerLoad = 1'b1;
          timerValue = 4'(nrw_pkg::ADDR_SETUP_NS / nrw_pkg::CLK_PERIOD_NS);
        end
      end
      nrw_pkg::ST_SETUP: begin
        if (timerDone) begin
          state_next = nrw_pkg::ST_STROBE;
          timerLoad = 1'b1;
          timerValue = 4'(nrw_pkg::SETUP_CYC - 1);
        end
      end
      nrw_pkg::ST_STROBE: begin
        if (timerDone) begin
          state_next = nrw_pkg::ST_HOLD;
          timerLoad = 1'b1;
          timerValue = 4'(nrw_pkg::HOLD_CYC - 1);
        end
      end
      nrw_pkg::ST_HOLD: begin
        if (timerDone) begin
          state_next = nrw_pkg::ST_RECOVER;
          timerLoad = 1'b1;
          timerValue = 4'(nrw_pkg::REC_CYC - 1);
        end
      end
      nrw_pkg::ST_RECOVER: begin
        if (timerDone) begin
          state_next = nrw_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = nrw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= nrw_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  assign strobeNext = (state_next == nrw_pkg::ST_STROBE);
  assign driveNext = strobeNext || (state_next == nrw_pkg::ST_HOLD);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_reg <= '0;
    end else if (take) begin
      hold_reg <= '{addr: reqData.addr, data: cleanData};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chipSel_reg <= 1'b1;
      writeStrobe_reg <= 1'b1;
      dqOe_reg <= 1'b0;
    end else begin
      // Select and strobe fall together and rise together: one edge sets both ends
      chipSel_reg <= !strobeNext;
      writeStrobe_reg <= !strobeNext;
      // Data driven from strobe fall through hold; device floats by then
      dqOe_reg <= driveNext;
    end
  end

  assign pins.chipSel_b = chipSel_reg;
  assign pins.writeStrobe_b = writeStrobe_reg;
  assign pins.outDrive_b = 1'b1;
  assign pins.addr = hold_reg.addr;
  assign pins.dqOut = hold_reg.data;
  assign pins.dqOe = dqOe_reg;

  // ----------------------------------------
  // Status
  // ----------------------------------------
  // Device ignores access in power fail, so refuse rather than lose it silently
  assign isIdle = (state_reg == nrw_pkg::ST_IDLE);
  assign doneNext = (state_reg == nrw_pkg::ST_RECOVER) && timerDone;
  assign refuseIdle = reqValid && isIdle && !powerGood;
  assign refuseLate = doneNext && lostWrite_reg;
  assign dayFlag = dayValue[nrw_pkg::BATTERY_OK_FLAG_BIT];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      done_reg <= doneNext;
      refused_reg <= refuseIdle || refuseLate;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lost_reg <= 1'b0;
    end else if (dayRead) begin
      lost_reg <= !dayFlag;
    end
  end

  // ----------------------------------------
  // Supply lost mid-write
  // ----------------------------------------
  // Strobe still completes so the pins end idle; only the report changes
  assign inFlight = (state_reg == nrw_pkg::ST_SETUP) || (state_reg == nrw_pkg::ST_STROBE);
  assign lostWrite_next = isIdle ? 1'b0 : (lostWrite_reg || (inFlight && !powerGood));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lostWrite_reg <= 1'b0;
    end else begin
      lostWrite_reg <= lostWrite_next;
    end
  end

  assign writeDone = done_reg;
  assign writeRefused = refused_reg;
  assign contentsLost = lost_reg;
endmodule : nrw_write_host

// ### nrw_pkg.sv
// Package for the timekeeping memory write-port host controller.
// Assumes a 10 MHz system clock and an asynchronous memory bus outside.
package nrw_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_PULSE_NS = 100;
  localparam int WRITE_DATA_SETUP_TIME_NS = 80;
  localparam int WRITE_DATA_HOLD_TIME_NS = 0;
  localparam int WRITE_RECOVERY_TIME_NS = 10;
  localparam int WRITE_TO_FLOAT_DELAY_NS = 40;
  localparam int ADDR_SETUP_NS = 0;
  // Least times round up, never below one cycle
  localparam int PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_RAW = (WRITE_DATA_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_RAW > PULSE_CYC) ? SETUP_RAW : PULSE_CYC;
  localparam int HOLD_RAW = (WRITE_DATA_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
  localparam int REC_RAW = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (REC_RAW < 1) ? 1 : REC_RAW;
  localparam int FLOAT_RAW = (WRITE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (FLOAT_RAW < 1) ? 1 : FLOAT_RAW;
  localparam int CNT_W = 4;
  // ----------------------------------------
  // Day register
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] DAY_ADDR = 15'h7FFC;
  localparam int BATTERY_OK_FLAG_BIT = 7;
  localparam logic [DATA_W-1:0] DAY_USED_MASK = 8'h47;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_RECOVER = 3'b100
  } nrw_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nrw_req_type;

  typedef struct packed {
    logic chipSel_b;
    logic writeStrobe_b;
    logic outDrive_b;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dqOut;
    logic dqOe;
  } nrw_pins_type;
endpackage : nrw_pkg

// ### nrw_cycle_timer.sv
// Down-counter timing each phase of the write cycle.
// Assumes load and the count come from the sequencer on the same clock.
`timescale 1ns/100ps
module nrw_cycle_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [nrw_pkg::CNT_W-1:0] loadValue,
  output logic done
);
  logic [nrw_pkg::CNT_W-1:0] count_reg;
  logic [nrw_pkg::CNT_W-1:0] count_next;

  assign done = (count_reg == 4'h0);
  assign count_next = load ? loadValue : (done ? count_reg : count_reg - 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= 4'h0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : nrw_cycle_timer

// ### nrw_write_host_properties.sv
// Checker on the write-port host pins.
// Assumes one clock, sync low reset.
`timescale 1ns/100ps
module nrw_write_host_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reqReady,
  input wire logic writeDone,
  input wire logic devReset_b,
  input wire logic dayRead,
  input wire logic [nrw_pkg::DATA_W-1:0] dayValue,
  input wire logic contentsLost,
  input nrw_pkg::nrw_pins_type pins
);
  wire ws = pins.writeStrobe_b;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_DRIVE: assert property (pins.outDrive_b) else $error("drive");
  AST_PAIR: assert property (pins.chipSel_b == ws) else $error("select");
  AST_PULSE: assert property ($fell(ws) |=> ws) else $error("width");
  AST_SETUP: assert property ($fell(ws) |-> pins.dqOe && $stable(pins.dqOut))
    else $error("setup");
  AST_HOLD: assert property ($rose(ws) |-> pins.dqOe && $stable(pins.addr))
    else $error("hold");
  AST_RECOV: assert property ($rose(ws) |-> ws [*4]) else $error("recovery");
  AST_DONE: assert property ($rose(ws) |-> ##2 writeDone) else $error("done");
  AST_FAIL: assert property (!devReset_b |-> !reqReady) else $error("fail");
  AST_LOST: assert property (dayRead |=> contentsLost == !$past(dayValue[7]))
    else $error("lost");
  AST_MASK: assert property (!ws && pins.addr == nrw_pkg::DAY_ADDR |->
    (pins.dqOut & ~nrw_pkg::DAY_USED_MASK) == 8'h00) else $error("mask");
endmodule : nrw_write_host_properties
bind nrw_write_host nrw_write_host_properties chk (.clk(clk), .rst_b(rst_b),
  .reqReady(reqReady), .writeDone(writeDone), .devReset_b(devReset_b), .dayRead(dayRead),
  .dayValue(dayValue), .contentsLost(contentsLost), .pins(pins));

// ### nrw_dev_model.sv
// Behavioural timekeeping memory on the pins.
// Assumes pins come straight from the host.
`timescale 1ns/100ps
module nrw_dev_model (
  input nrw_pkg::nrw_pins_type pins,
  input wire logic pwrOk,
  input wire logic battOk,
  output logic devReset_b,
  output logic [nrw_pkg::DATA_W-1:0] dayOut
);
  logic [7:0] mem [0:32767];
  logic battEn = 1'b0;
  wire wrAct = !pins.chipSel_b && !pins.writeStrobe_b;
  // Never drives data: output drive stays high, kept trivially
  assign devReset_b = pwrOk;
  assign dayOut = {battOk && battEn, mem[nrw_pkg::DAY_ADDR][6:0]};
  always @(posedge pwrOk) battEn = 1'b1;
  always @(negedge wrAct) if (pwrOk) mem[pins.addr] = pins.dqOut;
endmodule : nrw_dev_model

// ### nrw_write_host_tb.sv
// Bench for the write-port host block.
// Assumes the device model on the pins.
`timescale 1ns/100ps
module nrw_write_host_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reqValid = 1'b0;
  nrw_pkg::nrw_req_type reqData = '0;
  logic dayRead = 1'b0;
  logic pwrOk = 1'b0;
  logic battOk = 1'b1;
  logic reqReady, writeDone, writeRefused, devReset_b, contentsLost;
  logic [7:0] dayOut;
  nrw_pkg::nrw_pins_type pins;
  int err_count = 0;
  int checked = 0;
  nrw_write_host dut (.clk(clk), .rst_b(rst_b), .reqValid(reqValid), .reqData(reqData),
    .reqReady(reqReady), .writeDone(writeDone), .writeRefused(writeRefused),
    .devReset_b(devReset_b), .dayRead(dayRead), .dayValue(dayOut),
    .contentsLost(contentsLost), .pins(pins));
  nrw_dev_model dev (.pins(pins), .pwrOk(pwrOk), .battOk(battOk), .devReset_b(devReset_b),
    .dayOut(dayOut));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic results;
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic cmp(string name, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  function automatic logic [7:0] expData(logic [14:0] a, logic [7:0] d);
    return (a == nrw_pkg::DAY_ADDR) ? (d & nrw_pkg::DAY_USED_MASK) : d;
  endfunction : expData
  function automatic logic [7:0] expLat();
    return 8'(nrw_pkg::ADDR_SETUP_NS / nrw_pkg::CLK_PERIOD_NS + 1 + nrw_pkg::SETUP_CYC
      + nrw_pkg::HOLD_CYC + nrw_pkg::REC_CYC);
  endfunction : expLat
  task automatic wr(logic [14:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    reqData = {a, d};
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmp("ready", 8'h01, {7'h00, reqReady});
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    while (writeDone !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmp("latency", expLat(), n[7:0]);
    cmp("mem", expData(a, d), dev.mem[a]);
  endtask : wr
  task automatic dayChk(logic b);
    battOk = b;
    @(negedge clk);
    dayRead = 1'b1;
    @(negedge clk);
    dayRead = 1'b0;
    cmp("flag", {7'd0, b}, {7'd0, dayOut[7]});
    cmp("lost", {7'd0, !b}, {7'd0, contentsLost});
  endtask : dayChk
  initial begin
    logic [31:0] r;
    void'($urandom(75696));
    repeat (5) @(posedge clk);
    @(negedge clk);
    cmp("flag", 8'h00, {7'h00, dayOut[7]});
    pwrOk = 1'b1;
    rst_b = 1'b1;
    wr(15'h0000, 8'hFF);
    wr(15'h7FFF, 8'h00);
    wr(nrw_pkg::DAY_ADDR, 8'hFF);
    for (int i = 0; i < 30; i++) begin
      r = $urandom;
      wr((i % 4 == 0) ? nrw_pkg::DAY_ADDR : r[14:0], r[22:15]);
    end
    dayChk(1'b1);
    dayChk(1'b0);
    dayChk(1'b1);
    // Power fail: request held, memory must not change
    r = {24'd0, dev.mem[15'h0000]};
    pwrOk = 1'b0;
    reqData = {15'h0000, 8'h5A};
    reqValid = 1'b1;
    repeat (3) begin
      @(negedge clk);
      cmp("refused", 8'd1, {7'd0, writeRefused});
    end
    reqValid = 1'b0;
    pwrOk = 1'b1;
    cmp("blocked", r[7:0], dev.mem[15'h0000]);
    wr(15'h0001, 8'hA5);
    // Supply lost after take: cycle closes, write reported lost
    r = {24'h000000, dev.mem[15'h0001]};
    reqData = {15'h0001, 8'h3C};
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    pwrOk = 1'b0;
    repeat (3) @(negedge clk);
    pwrOk = 1'b1;
    @(negedge clk);
    cmp("done", 8'h01, {7'h00, writeDone});
    cmp("lostWrite", 8'h01, {7'h00, writeRefused});
    cmp("blocked", r[7:0], dev.mem[15'h0001]);
    results();
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule : nrw_write_host_tb
